/* File: hdl/bmsc_pkg.sv */
package bmsc_pkg;
  localparam int CLK_MHZ = 20;
  // configuration phase length
  localparam int CFG_TIME_US = 120;
  localparam int CFG_CYCLES = CFG_TIME_US * CLK_MHZ;
  // overvoltage qualify delay, least time
  localparam int OV_QUAL_US = 30;
  localparam int OV_QUAL_CYCLES = OV_QUAL_US * CLK_MHZ;
  localparam int CNT_W = 12;
  // feedback scale factors selected by the latched output range
  localparam logic [5:0] SCALE_LOW_RANGE = 6'h14;
  localparam logic [5:0] SCALE_HIGH_RANGE = 6'h3C;
  // register offsets (AXI4-Lite, byte addresses)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_FORCED_CONTINUOUS_MODE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one-hot mode state
  typedef enum logic [3:0] {
    BMSC_SHUTDOWN = 4'h1,
    BMSC_CONFIG = 4'h2,
    BMSC_ACTIVE = 4'h4,
    BMSC_BYPASS = 4'h8
  } bmsc_mode_t;

  // comparator results from the analog front end
  typedef struct packed {
    logic enable_above;
    logic sync_input_level_above;
    logic vcc_above_line_undervoltage_input;
    logic vcc_above_2v2;
    logic line_undervoltage_input_ok;
    logic overvoltage_status;
    logic current_above_forward_threshold;
    logic switch_node_below_zero_threshold;
    logic switch_node_below_negative_threshold;
    logic soft_start_above_1v5;
    logic output_range_high;
  } bmsc_cmp_t;

  // drive outputs towards the power stage
  typedef struct packed {
    logic comp_ground;
    logic soft_start_ground;
    logic power_good_output_ground;
    logic soft_start_run;
    logic error_amp_enable;
    logic enable_pulldown;
    logic frequency_set_pin_regulate;
    logic high_side_gate_drive_full;
    logic one_way_conduction_mode;
    logic zero_current_detect_negative;
  } bmsc_drv_t;
  // shutdown drive after reset: grounds on, one-way conduction until software picks
  localparam bmsc_drv_t DRV_RESET = 10'h382;
endpackage

/* File: hdl/bmsc_sync.sv */
`timescale 1ns/1ps
module bmsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

/* File: hdl/bmsc_timer.sv */
`timescale 1ns/1ps
module bmsc_timer #(
  parameter int CNT_W = 12,
  parameter int TARGET = 2400
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  output logic done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;

  // counts while run is high, restarts when run drops
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (!run) begin
      next_count = '0;
    end else if (count != CNT_W'(TARGET)) begin
      next_count = count + 1'b1;
    end
    next_done = run && (next_count == CNT_W'(TARGET));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule

/* File: hdl/bmsc_top.sv */
`timescale 1ns/1ps
// Functional notes
// - enable and sync low: shutdown, outputs grounded
// - enable or sync high leaves shutdown
// - first enable with vcc ok: 120 us configuration
// - enable and sync low or vcc below 2.2 V clears configuration
// - configuration: enable pulldown, frequency pin regulated
// - configuration done, line ok: active, soft-start
// - bypass drives high side fully on
// - bypass entry: overvoltage 30 us, forward current
// - one-way mode exits bypass at -5 mV
// - forced mode exits bypass at -150 mV
// - feedback scale factor follows latched range
// - forced mode keeps continuous conduction
// - one-way mode cuts high side at zero
// - soft-start below 1.5 V forces one-way mode
module bmsc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // comparators
  input wire bmsc_pkg::bmsc_cmp_t cmp_in,
  // power stage
  output bmsc_pkg::bmsc_drv_t drv_out,
  output logic [5:0] feedback_scale_factor,
  output logic [3:0] mode_state,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NCMP = $bits(bmsc_pkg::bmsc_cmp_t);

  bmsc_pkg::bmsc_cmp_t cmp;
  bmsc_pkg::bmsc_mode_t mode;
  bmsc_pkg::bmsc_mode_t next_mode;
  logic configured;
  logic next_configured;
  logic range_high;
  logic next_range_high;
  logic cfg_done;
  logic ov_qualified;
  logic forced_continuous_mode_select;
  logic enabled;
  logic bypass_exit;
  bmsc_pkg::bmsc_drv_t next_drv;
  logic [5:0] next_scale;

  // every comparator passes two flops before use
  bmsc_sync #(.WIDTH(NCMP)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(cmp_in),
    .dout(cmp)
  );

  bmsc_timer #(.CNT_W(bmsc_pkg::CNT_W), .TARGET(bmsc_pkg::CFG_CYCLES)) u_cfg_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(mode == bmsc_pkg::BMSC_CONFIG),
    .done(cfg_done)
  );

  // overvoltage must stand unbroken; any drop restarts the count
  bmsc_timer #(.CNT_W(bmsc_pkg::CNT_W), .TARGET(bmsc_pkg::OV_QUAL_CYCLES)) u_ov_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(cmp.overvoltage_status && mode == bmsc_pkg::BMSC_ACTIVE),
    .done(ov_qualified)
  );

  assign enabled = cmp.enable_above || cmp.sync_input_level_above;
  // the exit threshold depends on the light-load mode in force
  assign bypass_exit = !cmp.overvoltage_status ||
    (drv_out.one_way_conduction_mode ? cmp.switch_node_below_zero_threshold
                                     : cmp.switch_node_below_negative_threshold);

  always_comb begin
    next_mode = mode;
    next_configured = configured;
    next_range_high = range_high;
    if (!enabled) begin
      next_mode = bmsc_pkg::BMSC_SHUTDOWN;
      next_configured = 1'b0;
    end else begin
      if (!cmp.vcc_above_2v2) begin
        next_configured = 1'b0;
      end
      unique case (mode)
        bmsc_pkg::BMSC_SHUTDOWN: begin
          if (cmp.vcc_above_line_undervoltage_input) begin
            next_mode = configured ? bmsc_pkg::BMSC_ACTIVE : bmsc_pkg::BMSC_CONFIG;
          end
        end
        bmsc_pkg::BMSC_CONFIG: begin
          // range sampled throughout, frozen at completion
          if (!configured) begin
            next_range_high = cmp.output_range_high;
          end
          if (!cmp.vcc_above_line_undervoltage_input) begin
            next_mode = bmsc_pkg::BMSC_SHUTDOWN;
          end else if (cfg_done) begin
            next_configured = cmp.vcc_above_2v2;
            if (cmp.line_undervoltage_input_ok) begin
              next_mode = bmsc_pkg::BMSC_ACTIVE;
            end
          end
        end
        bmsc_pkg::BMSC_ACTIVE: begin
          if (!configured) begin
            next_mode = bmsc_pkg::BMSC_CONFIG;
          end else if (!cmp.line_undervoltage_input_ok) begin
            next_mode = bmsc_pkg::BMSC_SHUTDOWN;
          end else if (ov_qualified && cmp.current_above_forward_threshold) begin
            next_mode = bmsc_pkg::BMSC_BYPASS;
          end
        end
        bmsc_pkg::BMSC_BYPASS: begin
          if (bypass_exit || !configured) begin
            next_mode = bmsc_pkg::BMSC_ACTIVE;
          end
        end
        default: next_mode = bmsc_pkg::BMSC_SHUTDOWN;
      endcase
      // a configured device waiting on line ok sits in shutdown until ready
      if (mode == bmsc_pkg::BMSC_SHUTDOWN && configured && cmp.vcc_above_line_undervoltage_input &&
          !cmp.line_undervoltage_input_ok) begin
        next_mode = bmsc_pkg::BMSC_SHUTDOWN;
      end
    end
  end

  always_comb begin
    next_drv = '0;
    next_drv.comp_ground = (next_mode == bmsc_pkg::BMSC_SHUTDOWN);
    next_drv.soft_start_ground = (next_mode == bmsc_pkg::BMSC_SHUTDOWN) ||
                                 (next_mode == bmsc_pkg::BMSC_CONFIG);
    next_drv.power_good_output_ground = (next_mode != bmsc_pkg::BMSC_ACTIVE) &&
                                        (next_mode != bmsc_pkg::BMSC_BYPASS);
    next_drv.soft_start_run = (next_mode == bmsc_pkg::BMSC_ACTIVE) ||
                              (next_mode == bmsc_pkg::BMSC_BYPASS);
    next_drv.error_amp_enable = next_drv.soft_start_run;
    next_drv.enable_pulldown = (next_mode == bmsc_pkg::BMSC_CONFIG);
    next_drv.frequency_set_pin_regulate = (next_mode == bmsc_pkg::BMSC_CONFIG);
    next_drv.high_side_gate_drive_full = (next_mode == bmsc_pkg::BMSC_BYPASS);
    // low soft-start forces one-way conduction whatever software picks
    next_drv.one_way_conduction_mode = !forced_continuous_mode_select || !cmp.soft_start_above_1v5;
    // forced mode shifts zero detect negative for continuous conduction
    next_drv.zero_current_detect_negative = !next_drv.one_way_conduction_mode;
    next_scale = next_range_high ? bmsc_pkg::SCALE_HIGH_RANGE
                                 : bmsc_pkg::SCALE_LOW_RANGE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= bmsc_pkg::BMSC_SHUTDOWN;
      configured <= 1'b0;
      range_high <= 1'b0;
      drv_out <= bmsc_pkg::DRV_RESET;
      feedback_scale_factor <= bmsc_pkg::SCALE_LOW_RANGE;
    end else begin
      mode <= next_mode;
      configured <= next_configured;
      range_high <= next_range_high;
      drv_out <= next_drv;
      feedback_scale_factor <= next_scale;
    end
  end

  assign mode_state = mode;

  // axi4-lite slave: one write and one read at a time
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] ctrl;
  logic next_aw_held;
  logic next_w_held;
  logic [3:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [31:0] next_ctrl;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign forced_continuous_mode_select = ctrl[bmsc_pkg::CTRL_FORCED_CONTINUOUS_MODE_BIT];

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_ctrl = ctrl;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (next_aw_held && next_w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = bmsc_pkg::RESP_OKAY;
      if (next_aw_addr == bmsc_pkg::CTRL_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (next_w_strb[b]) begin
            next_ctrl[b*8 +: 8] = next_w_data[b*8 +: 8];
          end
        end
        next_ctrl[31:1] = '0;
      end else if (next_aw_addr != bmsc_pkg::STATUS_OFFSET) begin
        next_bresp = bmsc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = bmsc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        bmsc_pkg::CTRL_OFFSET: next_rdata = ctrl;
        bmsc_pkg::STATUS_OFFSET:
          next_rdata = {20'h00000, drv_out.one_way_conduction_mode, range_high,
                        configured, ov_qualified, 4'(mode), 4'(mode)};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = bmsc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= bmsc_pkg::CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      ctrl <= next_ctrl;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // checks
  sequence cfg_run_s;
    mode == bmsc_pkg::BMSC_CONFIG [*8];
  endsequence

  state_onehot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot(mode)) else $error("mode not one-hot");
  shutdown_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp.enable_above && !cmp.sync_input_level_above |=> mode == bmsc_pkg::BMSC_SHUTDOWN)
    else $error("no shutdown with enable and sync low");
  shutdown_ground_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == bmsc_pkg::BMSC_SHUTDOWN |-> drv_out.comp_ground && drv_out.soft_start_ground &&
    drv_out.power_good_output_ground) else $error("outputs not grounded in shutdown");
  config_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp.vcc_above_2v2 |=> !configured) else $error("configuration not cleared");
  config_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == bmsc_pkg::BMSC_CONFIG |-> drv_out.enable_pulldown &&
    drv_out.frequency_set_pin_regulate) else $error("config pins not driven");
  config_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(mode == bmsc_pkg::BMSC_CONFIG) |-> cfg_run_s or
    ##[0:7] !cmp.enable_above && !cmp.sync_input_level_above || !cmp.vcc_above_line_undervoltage_input)
    else $error("configuration phase cut short");
  bypass_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == bmsc_pkg::BMSC_BYPASS |-> drv_out.high_side_gate_drive_full)
    else $error("high side not full in bypass");
  bypass_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(mode == bmsc_pkg::BMSC_BYPASS) |-> $past(ov_qualified))
    else $error("bypass without qualified overvoltage");
  forced_de_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp.soft_start_above_1v5 |=> drv_out.one_way_conduction_mode)
    else $error("one-way mode not forced at low soft-start");
endmodule

/* File: testbench/bmsc_stage_model.sv */
`timescale 1ns/1ps
module bmsc_stage_model #(
  parameter int SS_HI = 100
) (
  // clock
  input wire logic aclk,
  // gate and soft-start drive
  input wire bmsc_pkg::bmsc_drv_t drv,
  // levels chosen by the bench
  input wire bmsc_pkg::bmsc_cmp_t cond,
  // comparator results
  output bmsc_pkg::bmsc_cmp_t cmp
);
  logic [7:0] ss_level;
  logic [7:0] next_ss_level;
  // soft-start capacitor: held at ground, else a slow ramp
  always_comb begin
    next_ss_level = ss_level;
    if (drv.soft_start_ground) begin
      next_ss_level = 8'h00;
    end else if (drv.soft_start_run && ss_level != 8'hFF) begin
      next_ss_level = ss_level + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    ss_level <= next_ss_level;
  end
  always_comb begin
    cmp = cond;
    cmp.soft_start_above_1v5 = (ss_level >= 8'(SS_HI));
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  bmsc_pkg::bmsc_cmp_t cond = '0;
  bmsc_pkg::bmsc_cmp_t cmp;
  bmsc_pkg::bmsc_drv_t drv;
  logic [5:0] scale;
  logic [3:0] mode;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b1;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b1;
  logic [31:0] rd;
  logic [1:0] rsp;
  int miscompares = 0;
  int check_count = 0;

  always #25 aclk = ~aclk;

  bmsc_top dut (.aclk(aclk), .aresetn(aresetn), .cmp_in(cmp), .drv_out(drv),
    .feedback_scale_factor(scale), .mode_state(mode), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  bmsc_stage_model stage (.aclk(aclk), .drv(drv), .cond(cond), .cmp(cmp));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wait_mode(input logic [3:0] m, input int lim);
    int i;
    for (i = 0; i < lim && mode !== m; i++) @(posedge aclk);
    check("mode", 32'(mode), 32'(m));
  endtask

  // bready and rready stay high for the whole run
  // waits for the answer however long; only the watchdog ends a hang
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic t_reset;
    check("mode", 32'(mode), 32'h1);
    check("drive", 32'(drv), 32'h382);
    check("scale", 32'(scale), 32'h14);
    axi_rd(4'h0, rd, rsp);
    check("ctrl", rd, 32'h0);
    axi_rd(4'h8, rd, rsp);
    check("unmapped read", 32'(rsp), 32'h2);
    $display("reset test done");
  endtask

  task automatic t_config;
    cond.vcc_above_line_undervoltage_input <= 1'b1;
    cond.vcc_above_2v2 <= 1'b1;
    cond.output_range_high <= 1'b1;
    cond.enable_above <= 1'b1;
    wait_mode(4'h2, 10);
    check("pulldown", 32'(drv.enable_pulldown), 32'h1);
    check("freq regulate", 32'(drv.frequency_set_pin_regulate), 32'h1);
    run(2380);
    check("mode", 32'(mode), 32'h2);
    // line still low: configuration done, waiting in place
    run(40);
    check("mode", 32'(mode), 32'h2);
    cond.line_undervoltage_input_ok <= 1'b1;
    wait_mode(4'h4, 10);
    check("ss run", 32'(drv.soft_start_run), 32'h1);
    check("error amp", 32'(drv.error_amp_enable), 32'h1);
    check("scale", 32'(scale), 32'h3C);
    cond.output_range_high <= 1'b0;
    $display("configuration test done");
  endtask

  task automatic t_softstart;
    axi_wr(4'h0, 32'h1, rsp);
    check("write resp", 32'(rsp), 32'h0);
    check("one way", 32'(drv.one_way_conduction_mode), 32'h1);
    run(120);
    check("one way", 32'(drv.one_way_conduction_mode), 32'h0);
    check("zcd negative", 32'(drv.zero_current_detect_negative), 32'h1);
    axi_rd(4'h4, rd, rsp);
    check("status", 32'({rd[10], rd[3:0]}), 32'h14);
    axi_wr(4'hC, 32'h1, rsp);
    check("unmapped write", 32'(rsp), 32'h2);
    $display("soft-start test done");
  endtask

  // an overvoltage gap restarts the qualify time
  task automatic t_bypass(input logic fp);
    axi_wr(4'h0, {31'h0, fp}, rsp);
    cond.current_above_forward_threshold <= 1'b1;
    cond.overvoltage_status <= 1'b1;
    run(300);
    cond.overvoltage_status <= 1'b0;
    run(5);
    cond.overvoltage_status <= 1'b1;
    run(590);
    check("mode", 32'(mode), 32'h4);
    wait_mode(4'h8, 30);
    check("high side", 32'(drv.high_side_gate_drive_full), 32'h1);
    cond.switch_node_below_zero_threshold <= 1'b1;
    if (fp) begin
      run(10);
      check("mode", 32'(mode), 32'h8);
      cond.switch_node_below_negative_threshold <= 1'b1;
    end
    wait_mode(4'h4, 10);
    check("high side", 32'(drv.high_side_gate_drive_full), 32'h0);
    cond.overvoltage_status <= 1'b0;
    cond.switch_node_below_zero_threshold <= 1'b0;
    cond.switch_node_below_negative_threshold <= 1'b0;
    run(10);
    check("scale", 32'(scale), 32'h3C);
    $display("bypass test done");
  endtask

  task automatic t_reconfig;
    cond.enable_above <= 1'b0;
    wait_mode(4'h1, 10);
    check("grounds", 32'(drv[9:7]), 32'h7);
    cond.sync_input_level_above <= 1'b1;
    wait_mode(4'h2, 10);
    run(2380);
    wait_mode(4'h4, 40);
    check("scale", 32'(scale), 32'h14);
    // a dip below 2.2 V drops the configuration and reruns it
    cond.vcc_above_2v2 <= 1'b0;
    run(4);
    cond.vcc_above_2v2 <= 1'b1;
    wait_mode(4'h2, 10);
    axi_rd(4'h4, rd, rsp);
    check("configured", 32'(rd[9]), 32'h0);
    $display("reconfiguration test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    run(4);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_config();
    t_softstart();
    t_bypass(1'b1);
    t_bypass(1'b0);
    t_reconfig();
    print_verdict();
  end

  // whole run needs under 10000 cycles
  initial begin
    run(20000);
    miscompares++;
    $display("unexpected watchdog expiry");
    print_verdict();
  end
endmodule
